// >>> pkg/ofc_pkg.sv
// Constants, types and register layout of the on-chip flash controller
// Operation
// - Separate data and control ports on the bus
// - Data port serves flash reads and programs
// - Single read, burst read, program, erases, protection
// - Read-program mode keeps both ports, all sectors
// - Read-only mode: data port, reads only
// - Hidden region refuses reads and programs
// - Hidden mode applies to configuration sector only
// - Parallel style moves 32-bit words
// - Serial style moves words one bit per beat
// - Wrapping bursts in parallel style only
// - Parallel program writes exactly one word
// - Serial program writes exactly one word
// - Control read returns addressed register contents
// - Busy codes: idle, erase, program, read
// - Control register sits at control word 1
// - Erase request accepted only while idle
package ofc_pkg;
    // Array shape: 3 sectors x 2 pages x 4 words, index {sector,page,word}
    localparam int unsigned WORD_W = 32;
    localparam int unsigned IDX_W = 5;
    localparam int NWORDS = 24;
    localparam logic [1:0] NSECTORS = 2'h3;
    localparam logic [1:0] CFG_SECTOR = 2'h2;
    localparam logic [WORD_W-1:0] EMPTY_WORD = 32'hffff_ffff;
    // Bus map: haddr bit 8 picks the control port
    localparam int unsigned REGION_BIT = 8;
    localparam logic [5:0] CTL_STATUS_WORD = 6'h00;
    localparam logic [5:0] CTL_CTRL_WORD = 6'h01;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // Busy field codes
    localparam logic [1:0] BUSY_IDLE = 2'h0;
    localparam logic [1:0] BUSY_ERASE = 2'h1;
    localparam logic [1:0] BUSY_PROG = 2'h2;
    localparam logic [1:0] BUSY_READ = 2'h3;
    // Erase kinds in the control register
    localparam logic [1:0] EK_SECTOR = 2'h1;
    localparam logic [1:0] EK_PAGE = 2'h2;
    // Burst counts
    localparam logic [7:0] BC_SINGLE_PAR = 8'h01;
    localparam logic [7:0] BC_SINGLE_SER = 8'h20;
    localparam logic [7:0] BURST_MAX = 8'h80;
    localparam logic [7:0] WRAP_LEN = 8'h04;
    localparam logic [5:0] SER_BEATS = 6'h20;
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS = 32;
    localparam int ERASE_TIME_NS = 256;
    localparam logic [7:0] PROG_CYC = 8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] ERASE_CYC = 8'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Reset values: all sectors write protected, single-word burst count
    localparam logic [31:0] CTRL_RST_PAR = 32'h0001_0700;
    localparam logic [31:0] CTRL_RST_SER = 32'h0020_0700;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;

    typedef enum logic {OFC_RW, OFC_RO} ofc_access_t;
    typedef enum logic {OFC_PAR, OFC_SER} ofc_style_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_READ = 4'b0010,
        S_PROG = 4'b0100,
        S_ERASE = 4'b1000
    } ofc_state_t;

    typedef struct packed {
        logic [6:0] rsv_hi;
        logic wrap;
        logic [7:0] bcount;
        logic [4:0] rsv_mid;
        logic [2:0] wprot;
        logic [1:0] rsv_lo;
        logic [1:0] ekind;
        logic [3:0] eidx;
    } ofc_ctrl_t;

    typedef struct packed {
        logic [26:0] rsv;
        logic erase_ok;
        logic write_ok;
        logic read_ok;
        logic [1:0] busy;
    } ofc_stat_t;

    typedef struct packed {
        logic [31:0] addr;
        logic write;
        logic ctl;
        logic word;
    } ofc_aph_t;
endpackage

// >>> src/ofc_flash_array.sv
// Flash word storage with program and erase
`timescale 1ns/10ps
module ofc_flash_array
    import ofc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WORD_W-1:0] rd_data,
    input wire logic pgm_en,
    input wire logic [IDX_W-1:0] pgm_idx,
    input wire logic [WORD_W-1:0] pgm_data,
    input wire logic ers_en,
    input wire logic ers_page,
    input wire logic [2:0] ers_loc
);
    logic [WORD_W-1:0] mem_q [NWORDS];
    logic [WORD_W-1:0] mem_d [NWORDS];

    genvar gi;
    generate
        for (gi = 0; gi < NWORDS; gi++) begin : g_word
            localparam logic [IDX_W-1:0] WI = IDX_W'(gi);
            // Erase sets whole sector or page; program can only clear bits
            always_comb begin
                mem_d[gi] = mem_q[gi];
                if (ers_en && WI[4:3] == ers_loc[2:1] && (!ers_page || WI[2] == ers_loc[0])) begin
                    mem_d[gi] = EMPTY_WORD;
                end else if (pgm_en && pgm_idx == WI) begin
                    mem_d[gi] = mem_q[gi] & pgm_data;
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_q[gi] <= EMPTY_WORD;
                end else begin
                    mem_q[gi] <= mem_d[gi];
                end
            end
        end
    endgenerate

    // Out-of-range index reads as erased flash
    assign rd_data = (rd_idx < IDX_W'(NWORDS)) ? mem_q[rd_idx] : EMPTY_WORD;
endmodule // ofc_flash_array

// >>> src/ofc_flash_ctrl.sv
// On-chip flash controller: AHB-Lite data and control ports over the flash array
`timescale 1ns/10ps
module ofc_flash_ctrl
    import ofc_pkg::*;
#(
    parameter ofc_access_t ACCESS = OFC_RW,
    parameter bit CFG_HIDDEN = 1'b0,
    parameter ofc_style_t STYLE = OFC_PAR
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    localparam bit SER = (STYLE == OFC_SER);
    localparam logic [7:0] BC_SINGLE = SER ? BC_SINGLE_SER : BC_SINGLE_PAR;
    localparam logic [31:0] CTRL_RST = SER ? CTRL_RST_SER : CTRL_RST_PAR;

    ofc_state_t st_q, st_d;
    ofc_aph_t aph_q, aph_d;
    ofc_ctrl_t ctrl_q, ctrl_d, wv;
    ofc_stat_t stat_q, stat_d, stat_v;
    logic pend_q, pend_d, cw_q, cw_d, ok_q, ok_d, epage_q, epage_d;
    logic [7:0] cnt_q, cnt_d, bleft_q, bleft_d, words;
    logic [IDX_W-1:0] idx_q, idx_d, bptr_q, bptr_d, aidx;
    logic [31:0] wdata_q, wdata_d, hrdata_q, hrdata_d, arr_rdata, lane_in, lane_out;
    logic hready_q, hready_d, hresp_q;
    logic accept, lane_start, lane_busy, pgm_en, ers_en, rd_done, pg_done, bc_ok;
    logic [1:0] esec;

    // Busy field code for each state
    function automatic logic [1:0] busy_of(input ofc_state_t s);
        case (s)
            S_ERASE: busy_of = BUSY_ERASE;
            S_PROG: busy_of = BUSY_PROG;
            S_READ: busy_of = BUSY_READ;
            default: busy_of = BUSY_IDLE;
        endcase
    endfunction

    // Sector reachable: in range, not hidden, optionally not protected
    function automatic logic sec_open(input logic [1:0] sec, input logic [2:0] wp,
                                      input logic chk);
        sec_open = (sec < NSECTORS) && !(CFG_HIDDEN && sec == CFG_SECTOR);
        if (chk && sec < NSECTORS && wp[sec]) begin
            sec_open = 1'b0;
        end
    endfunction

    // Next word of a burst: wrap inside an aligned block or increment
    function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] i, input logic w);
        if (w) begin
            next_idx = {i[4:2], i[1:0] + 2'h1};
        end else begin
            next_idx = IDX_W'(i + 5'h01);
        end
    endfunction

    // Control port read mux; read-only builds expose no control port
    function automatic logic [31:0] ctl_word(input logic [5:0] w, input ofc_stat_t s,
                                            input ofc_ctrl_t c);
        ctl_word = 32'h0000_0000;
        if (ACCESS == OFC_RW) begin
            if (w == CTL_STATUS_WORD) begin
                ctl_word = s;
            end else if (w == CTL_CTRL_WORD) begin
                ctl_word = c;
            end
        end
    endfunction

    ofc_flash_array u_array (
        .clk(hclk),
        .rst_n(hresetn),
        .rd_idx(idx_q),
        .rd_data(arr_rdata),
        .pgm_en(pgm_en),
        .pgm_idx(idx_q),
        .pgm_data(SER ? lane_out : wdata_q),
        .ers_en(ers_en),
        .ers_page(epage_q),
        .ers_loc(idx_q[2:0])
    );

    ofc_serial_lane u_lane (
        .clk(hclk),
        .rst_n(hresetn),
        .start(lane_start),
        .word_in(lane_in),
        .busy(lane_busy),
        .word_out(lane_out)
    );

    // Status view with live busy field
    always_comb begin
        stat_v = stat_q;
        stat_v.busy = busy_of(st_q);
    end

    // Burst count legality per style; serial moves 32 beats per word
    always_comb begin
        wv = ofc_ctrl_t'(hwdata);
        aidx = aph_q.addr[IDX_W+1:2];
        esec = (wv.ekind == EK_PAGE) ? wv.eidx[2:1] : wv.eidx[1:0];
        if (SER) begin
            words = {5'h00, ctrl_q.bcount[7:5]};
            bc_ok = ctrl_q.bcount[4:0] == 5'h00 && ctrl_q.bcount != 8'h00
                    && !ctrl_q.wrap;
        end else begin
            words = ctrl_q.bcount;
            bc_ok = ctrl_q.bcount != 8'h00 && ctrl_q.bcount <= BURST_MAX
                    && (!ctrl_q.wrap || ctrl_q.bcount == WRAP_LEN);
        end
        rd_done = (st_q == S_READ) && (!SER || (cnt_q != 8'h00 && !lane_busy));
        pg_done = (st_q == S_PROG) && cnt_q >= PROG_CYC - 8'h01 && !lane_busy;
    end

    // Bus slave and operation sequencer
    always_comb begin
        st_d = st_q;
        aph_d = aph_q;
        ctrl_d = ctrl_q;
        stat_d = stat_q;
        pend_d = pend_q;
        ok_d = ok_q;
        epage_d = epage_q;
        cnt_d = cnt_q;
        bleft_d = bleft_q;
        idx_d = idx_q;
        bptr_d = bptr_q;
        wdata_d = wdata_q;
        hrdata_d = hrdata_q;
        hready_d = hready_q;
        lane_start = 1'b0;
        lane_in = arr_rdata;
        pgm_en = 1'b0;
        ers_en = 1'b0;
        accept = hsel && htrans[1] && hready;
        cw_d = accept && haddr[REGION_BIT] && hwrite;
        // Address phase: control reads answer at once, data accesses stall
        if (accept) begin
            aph_d = '{addr: haddr, write: hwrite, ctl: haddr[REGION_BIT],
                      word: hsize == HSIZE_WORD};
            if (haddr[REGION_BIT]) begin
                if (!hwrite) begin
                    hrdata_d = ctl_word(haddr[7:2], stat_v, ctrl_q);
                end
            end else begin
                pend_d = 1'b1;
                hready_d = 1'b0;
            end
        end
        // Control write data phase; erase starts only from idle
        if (cw_q && ACCESS == OFC_RW && aph_q.addr[7:2] == CTL_CTRL_WORD) begin
            ctrl_d = wv;
            if ((wv.ekind == EK_SECTOR || wv.ekind == EK_PAGE) && st_q == S_IDLE
                && !pend_q) begin
                st_d = S_ERASE;
                cnt_d = 8'h00;
                epage_d = (wv.ekind == EK_PAGE);
                idx_d = {2'h0, esec, (wv.ekind == EK_PAGE) ? wv.eidx[0] : 1'b0};
                ok_d = aph_q.word && sec_open(esec, wv.wprot, 1'b1);
            end
        end
        case (st_q)
            S_IDLE: begin
                if (pend_q) begin
                    pend_d = 1'b0;
                    cnt_d = 8'h00;
                    if (aph_q.write) begin
                        st_d = S_PROG;
                        idx_d = aidx;
                        wdata_d = hwdata;
                        ok_d = ACCESS == OFC_RW && aph_q.word
                               && ctrl_q.bcount == BC_SINGLE
                               && aph_q.addr[REGION_BIT-1:IDX_W+2] == '0
                               && aidx < IDX_W'(NWORDS)
                               && sec_open(aidx[4:3], ctrl_q.wprot, 1'b1);
                    end else begin
                        st_d = S_READ;
                        // Later reads of a running burst follow the burst pointer
                        idx_d = (bleft_q != 8'h00) ? bptr_q : aidx;
                        ok_d = bc_ok && ((bleft_q != 8'h00) || (aidx < IDX_W'(NWORDS)
                               && aph_q.addr[REGION_BIT-1:IDX_W+2] == '0))
                               && sec_open(((bleft_q != 8'h00) ? bptr_q[4:3] : aidx[4:3]),
                                           ctrl_q.wprot, 1'b0);
                    end
                end
            end
            S_READ: begin
                if (SER && cnt_q == 8'h00) begin
                    lane_start = 1'b1;
                    cnt_d = 8'h01;
                end
                if (rd_done) begin
                    hrdata_d = !ok_q ? EMPTY_WORD : (SER ? lane_out : arr_rdata);
                    stat_d.read_ok = ok_q;
                    hready_d = 1'b1;
                    st_d = S_IDLE;
                    if (bleft_q != 8'h00) begin
                        bleft_d = bleft_q - 8'h01;
                        bptr_d = next_idx(idx_q, ctrl_q.wrap);
                    end else if (ok_q && words > 8'h01) begin
                        bleft_d = words - 8'h01;
                        bptr_d = next_idx(idx_q, ctrl_q.wrap);
                    end
                    if (!ok_q) begin
                        bleft_d = 8'h00;
                    end
                end
            end
            S_PROG: begin
                cnt_d = cnt_q + 8'h01;
                if (SER && cnt_q == 8'h00) begin
                    lane_start = 1'b1;
                    lane_in = wdata_q;
                end
                if (pg_done) begin
                    pgm_en = ok_q;
                    stat_d.write_ok = ok_q;
                    hready_d = 1'b1;
                    st_d = S_IDLE;
                end
            end
            S_ERASE: begin
                cnt_d = cnt_q + 8'h01;
                if (cnt_q == ERASE_CYC - 8'h01) begin
                    ers_en = ok_q;
                    stat_d.erase_ok = ok_q;
                    st_d = S_IDLE;
                end
            end
            default: begin
                st_d = S_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            aph_q <= '0;
            ctrl_q <= ofc_ctrl_t'(CTRL_RST);
            stat_q <= ofc_stat_t'(STAT_RST);
            pend_q <= 1'b0;
            cw_q <= 1'b0;
            ok_q <= 1'b0;
            epage_q <= 1'b0;
            cnt_q <= 8'h00;
            bleft_q <= 8'h00;
            idx_q <= '0;
            bptr_q <= '0;
            wdata_q <= 32'h0000_0000;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            st_q <= st_d;
            aph_q <= aph_d;
            ctrl_q <= ctrl_d;
            stat_q <= stat_d;
            pend_q <= pend_d;
            cw_q <= cw_d;
            ok_q <= ok_d;
            epage_q <= epage_d;
            cnt_q <= cnt_d;
            bleft_q <= bleft_d;
            idx_q <= idx_d;
            bptr_q <= bptr_d;
            wdata_q <= wdata_d;
            hrdata_q <= hrdata_d;
            hready_q <= hready_d;
            hresp_q <= 1'b0; // Every answer is OKAY
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hready_q;
    assign hresp = hresp_q;

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence data_wr_s;
        accept && !haddr[REGION_BIT] && hwrite && st_q == S_IDLE && !pend_q && !cw_q;
    endsequence
    sequence data_rd_s;
        accept && !haddr[REGION_BIT] && !hwrite && st_q == S_IDLE && !pend_q && !cw_q;
    endsequence
    sequence shift_run_s;
        lane_busy [*8] ##24 lane_busy ##1 !lane_busy;
    endsequence

    ctl_read_a: assert property (accept && haddr[REGION_BIT] && !hwrite
        && haddr[7:2] == CTL_CTRL_WORD && ACCESS == OFC_RW
        |=> hreadyout && hrdata == $past(ctrl_q))
        else $error("control register read returned wrong value");
    busy_prog_a: assert property (data_wr_s |=> ##1 stat_v.busy == 2'b10)
        else $error("program did not show program busy code");
    busy_read_a: assert property (data_rd_s |=> ##1 stat_v.busy == 2'b11)
        else $error("read did not show read busy code");
    erase_ignore_a: assert property (cw_q && st_q == S_ERASE
        && cnt_q < ERASE_CYC - 8'h01 |=> st_q == S_ERASE && cnt_q == $past(cnt_q) + 8'h01)
        else $error("erase restarted while busy");
    read_only_a: assert property (pgm_en || ers_en |-> ACCESS == OFC_RW)
        else $error("flash changed in read-only build");
    hidden_rd_a: assert property (rd_done && CFG_HIDDEN && idx_q[4:3] == CFG_SECTOR
        |=> hreadyout && hrdata == EMPTY_WORD && !stat_q.read_ok)
        else $error("hidden sector returned data");
    single_word_a: assert property (pgm_en |-> ctrl_q.bcount == BC_SINGLE)
        else $error("program with wrong burst count");
    serial_beats_a: assert property (lane_start |=> shift_run_s)
        else $error("serial word did not take 32 beats");
    no_wrap_ser_a: assert property (st_q == S_READ && SER && ctrl_q.wrap |-> !ok_q)
        else $error("wrapping burst accepted in serial style");
    data_stall_a: assert property (pend_q |-> !hreadyout)
        else $error("data access answered before service");
endmodule // ofc_flash_ctrl

// >>> src/ofc_serial_lane.sv
// One-bit-per-beat word lane used by the serial interface style
`timescale 1ns/10ps
module ofc_serial_lane
    import ofc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [WORD_W-1:0] word_in,
    output logic busy,
    output logic [WORD_W-1:0] word_out
);
    logic [WORD_W-1:0] tx_q, tx_d, rx_q, rx_d;
    logic [5:0] beat_q, beat_d;

    // Shift out MSB first, collect at the far end; 32 beats per word
    always_comb begin
        tx_d = tx_q;
        rx_d = rx_q;
        beat_d = beat_q;
        if (start) begin
            tx_d = word_in;
            beat_d = SER_BEATS;
        end else if (beat_q != 6'h00) begin
            rx_d = {rx_q[WORD_W-2:0], tx_q[WORD_W-1]};
            tx_d = {tx_q[WORD_W-2:0], 1'b0};
            beat_d = beat_q - 6'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_q <= '0;
            rx_q <= '0;
            beat_q <= 6'h00;
        end else begin
            tx_q <= tx_d;
            rx_q <= rx_d;
            beat_q <= beat_d;
        end
    end

    assign busy = (beat_q != 6'h00);
    assign word_out = rx_q;
endmodule // ofc_serial_lane

// >>> verif/ofc_ahb_host.sv
// Bus host model that issues single-word AHB-Lite transfers
`timescale 1ns/10ps
module ofc_ahb_host
    import ofc_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    // Idle bus from time zero
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
    end

    // One whole word; released address and write-data lines show inverted values so stale data never looks valid
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= HSIZE_WORD;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        haddr <= ~a;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
        hwdata <= ~d;
    endtask
endmodule // ofc_ahb_host

// >>> verif/test_onchip_user_flash_controller.sv
// Self-checking bench for the flash controller in parallel, serial and read-only builds
`timescale 1ns/10ps
module test_onchip_user_flash_controller;
    import ofc_pkg::*;
    localparam logic [31:0] STAT_A = 32'h0000_0100;
    localparam logic [31:0] CTRL_A = 32'h0000_0104;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int error_cnt = 0;
    int n_compared = 0;

    // Clock and bus ready loop-back
    always #2 hclk = ~hclk;
    assign hready = hreadyout;

    ofc_flash_ctrl ofc_flash_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    ofc_ahb_host ofc_ahb_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));

    // Serial build with the configuration sector hidden, and a read-only build
    logic hsel_s, hwrite_s, hreadyout_s, hsel_r, hwrite_r, hreadyout_r;
    logic [1:0] htrans_s, htrans_r;
    logic [2:0] hsize_s, hsize_r;
    logic [31:0] haddr_s, hwdata_s, hrdata_s, haddr_r, hwdata_r, hrdata_r;
    ofc_flash_ctrl #(.ACCESS(OFC_RW), .CFG_HIDDEN(1'b1), .STYLE(OFC_SER)) ofc_flash_ctrl_s_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel_s), .haddr(haddr_s), .htrans(htrans_s),
        .hwrite(hwrite_s), .hsize(hsize_s), .hwdata(hwdata_s), .hready(hreadyout_s),
        .hrdata(hrdata_s), .hreadyout(hreadyout_s), .hresp());
    ofc_ahb_host ofc_ahb_host_s_i (.hclk(hclk), .hready(hreadyout_s), .hrdata(hrdata_s),
        .hsel(hsel_s), .haddr(haddr_s), .htrans(htrans_s), .hwrite(hwrite_s),
        .hsize(hsize_s), .hwdata(hwdata_s));
    ofc_flash_ctrl #(.ACCESS(OFC_RO), .CFG_HIDDEN(1'b0), .STYLE(OFC_PAR)) ofc_flash_ctrl_r_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel_r), .haddr(haddr_r), .htrans(htrans_r),
        .hwrite(hwrite_r), .hsize(hsize_r), .hwdata(hwdata_r), .hready(hreadyout_r),
        .hrdata(hrdata_r), .hreadyout(hreadyout_r), .hresp());
    ofc_ahb_host ofc_ahb_host_r_i (.hclk(hclk), .hready(hreadyout_r), .hrdata(hrdata_r),
        .hsel(hsel_r), .haddr(haddr_r), .htrans(htrans_r), .hwrite(hwrite_r),
        .hsize(hsize_r), .hwdata(hwdata_r));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus_rd(input logic [31:0] a, output logic [31:0] d);
        ofc_ahb_host_i.xfer(1'b0, a, 32'h0, d);
        check({31'h0, hresp}, 32'h0);
    endtask

    task automatic bus_wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        ofc_ahb_host_i.xfer(1'b1, a, d, r);
    endtask

    // Polls status under a bound; a stuck busy field shows up in later checks
    task automatic wait_idle;
        for (int i = 0; i < 100; i++) begin
            bus_rd(STAT_A, rd);
            if (rd[1:0] === BUSY_IDLE) break;
        end
    endtask

    task automatic t_reset_regs;
        bus_rd(CTRL_A, rd);
        check(rd, CTRL_RST_PAR);
        bus_rd(STAT_A, rd);
        check(rd, STAT_RST);
        bus_rd(32'h0000_0108, rd);
        check(rd, 32'h0);
    endtask

    // Plain read with no control-port set-up
    task automatic t_read_erased;
        bus_rd(32'h0000_0000, rd);
        check(rd, EMPTY_WORD);
        bus_rd(STAT_A, rd);
        check(rd & 32'h7, 32'h4);
    endtask

    // Protected sector refuses, then unprotected word is written once
    task automatic t_program;
        bus_wr(32'h0000_0020, 32'hc3c3_0008);
        bus_rd(STAT_A, rd);
        check(rd & 32'h8, 32'h0);
        bus_rd(32'h0000_0020, rd);
        check(rd, EMPTY_WORD);
        bus_wr(CTRL_A, 32'h0001_0000);
        bus_rd(CTRL_A, rd);
        check(rd, 32'h0001_0000);
        bus_wr(32'h0000_0020, 32'hc3c3_0008);
        bus_rd(STAT_A, rd);
        check(rd & 32'h8, 32'h8);
        bus_rd(32'h0000_0020, rd);
        check(rd, 32'hc3c3_0008);
        bus_wr(32'h0000_0060, 32'h0);
        bus_rd(STAT_A, rd);
        check(rd & 32'h8, 32'h0);
    endtask

    // Sector erase, a page erase refused while busy, then accepted when idle
    task automatic t_erase;
        bus_wr(CTRL_A, 32'h0001_0010);
        bus_rd(STAT_A, rd);
        check(rd & 32'h3, {30'h0, BUSY_ERASE});
        bus_wr(CTRL_A, 32'h0001_0022);
        bus_rd(32'h0000_0000, rd);
        check(rd, EMPTY_WORD);
        bus_rd(32'h0000_0020, rd);
        check(rd, 32'hc3c3_0008);
        wait_idle();
        check(rd & 32'h13, 32'h10);
        bus_wr(CTRL_A, 32'h0001_0022);
        wait_idle();
        bus_rd(32'h0000_0020, rd);
        check(rd, EMPTY_WORD);
    endtask

    // Four-word wrapping burst starting mid-block, then an out-of-range read
    task automatic t_wrap;
        bus_wr(CTRL_A, 32'h0001_0000);
        for (int k = 0; k < 4; k++) begin
            bus_wr(32'(k * 4), 32'h5a5a_0000 | 32'(k));
        end
        bus_wr(CTRL_A, 32'h0104_0000);
        for (int i = 0; i < 4; i++) begin
            bus_rd(32'h0000_0008, rd);
            check(rd, 32'h5a5a_0000 | 32'((2 + i) % 4));
        end
        bus_rd(32'h0000_0060, rd);
        check(rd, EMPTY_WORD);
        bus_rd(STAT_A, rd);
        check(rd & 32'h4, 32'h0);
    endtask

    // Serial word program and read, hidden sector refused, wrapping burst refused
    task automatic t_serial;
        ofc_ahb_host_s_i.xfer(1'b0, CTRL_A, 32'h0, rd);
        check(rd, CTRL_RST_SER);
        ofc_ahb_host_s_i.xfer(1'b1, CTRL_A, 32'h0020_0000, rd);
        ofc_ahb_host_s_i.xfer(1'b1, 32'h0000_0004, 32'h3c96_a50f, rd);
        ofc_ahb_host_s_i.xfer(1'b0, STAT_A, 32'h0, rd);
        check(rd & 32'h8, 32'h8);
        ofc_ahb_host_s_i.xfer(1'b0, 32'h0000_0004, 32'h0, rd);
        check(rd, 32'h3c96_a50f);
        ofc_ahb_host_s_i.xfer(1'b1, 32'h0000_0040, 32'h0, rd);
        ofc_ahb_host_s_i.xfer(1'b0, STAT_A, 32'h0, rd);
        check(rd & 32'h8, 32'h0);
        ofc_ahb_host_s_i.xfer(1'b0, 32'h0000_0040, 32'h0, rd);
        check(rd, EMPTY_WORD);
        ofc_ahb_host_s_i.xfer(1'b0, STAT_A, 32'h0, rd);
        check(rd & 32'h4, 32'h0);
        ofc_ahb_host_s_i.xfer(1'b1, CTRL_A, 32'h0120_0000, rd);
        ofc_ahb_host_s_i.xfer(1'b0, 32'h0000_0004, 32'h0, rd);
        check(rd, EMPTY_WORD);
    endtask

    // Read-only build: control port absent, program refused, reads served
    task automatic t_read_only;
        ofc_ahb_host_r_i.xfer(1'b1, CTRL_A, 32'h0001_0000, rd);
        ofc_ahb_host_r_i.xfer(1'b0, CTRL_A, 32'h0, rd);
        check(rd, 32'h0);
        ofc_ahb_host_r_i.xfer(1'b1, 32'h0000_0000, 32'h0, rd);
        ofc_ahb_host_r_i.xfer(1'b0, 32'h0000_0000, 32'h0, rd);
        check(rd, EMPTY_WORD);
    endtask

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence; reset released at a rising edge
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_regs();
        t_read_erased();
        t_program();
        t_erase();
        t_wrap();
        t_serial();
        t_read_only();
        stop_test();
    end

    // Watchdog: the sequence needs under a thousand cycles; the limit is 10000 cycles
    initial begin
        #40000;
        error_cnt++;
        stop_test();
    end
endmodule // test_onchip_user_flash_controller
